// *** bw_overflow_regs.sv ***
`timescale 1ns/1ps
module bw_overflow_regs #(
  parameter int NUM_MON = 64,
  parameter int NUM_RIS = 1,
  parameter bit BITMAP_PRESENT_FLAG = 1'b1,
  parameter bit HAS_V1P1 = 1'b1,
  parameter bit MSI_PRESENT_FLAG = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire bw_ovf_pkg::reg_req_s req,
  output logic rsp_valid_q,
  output logic [31:0] rsp_rdata_q,
  input wire bw_ovf_pkg::selected_monitor_index_s sel_s,
  input wire bw_ovf_pkg::selected_monitor_index_s sel_ns,
  input wire logic [NUM_RIS*NUM_MON-1:0] oflow_s,
  input wire logic [NUM_RIS*NUM_MON-1:0] oflow_long_s,
  input wire logic [NUM_RIS*NUM_MON-1:0] oflow_ns,
  input wire logic [NUM_RIS*NUM_MON-1:0] oflow_long_ns,
  input wire logic [1:0] ovf_event,
  input wire logic msi_ready,
  output logic msi_valid_q,
  output bw_ovf_pkg::msi_wr_s msi_q,
  output logic [1:0] irq_q
);

  localparam bit MSI_OK = HAS_V1P1 & MSI_PRESENT_FLAG;

  logic [31:0] bitmap [2];
  logic [31:0] addr_l_word [2];
  logic [31:0] addr_h_word [2];
  logic [31:0] data_word [2];
  logic [31:0] attr_word [2];
  logic [51:0] full_addr [2];
  logic [1:0] msi_write_enable;
  logic [1:0] pend;
  logic [1:0] grant;
  logic [1:0] wr_l;
  logic [1:0] wr_h;
  logic [1:0] wr_data;
  logic [1:0] wr_attr;

  // access decode
  wire hit_bitmap = req.addr == bw_ovf_pkg::OFF_BITMAP;
  wire hit_l = req.addr == bw_ovf_pkg::OFF_ADDR_L;
  wire hit_h = req.addr == bw_ovf_pkg::OFF_ADDR_H;
  wire hit_data = req.addr == bw_ovf_pkg::OFF_DATA;
  wire hit_attr = req.addr == bw_ovf_pkg::OFF_ATTR;
  wire do_write = req.valid & req.write;
  wire do_read = req.valid & ~req.write;
  wire sec_idx = req.secure;

  bitmap_gather #(
    .NUM_MON(NUM_MON),
    .NUM_RIS(NUM_RIS)
  ) u_gather_ns (
    .sel(sel_ns),
    .oflow(oflow_ns),
    .oflow_long(oflow_long_ns),
    .bitmap(bitmap[bw_ovf_pkg::SEC_NS])
  );

  bitmap_gather #(
    .NUM_MON(NUM_MON),
    .NUM_RIS(NUM_RIS)
  ) u_gather_s (
    .sel(sel_s),
    .oflow(oflow_s),
    .oflow_long(oflow_long_s),
    .bitmap(bitmap[bw_ovf_pkg::SEC_S])
  );

  for (genvar g = 0; g < 2; g++) begin : g_copy
    // each frame writes only its own copy
    assign wr_l[g] = do_write & hit_l & (sec_idx == 1'(g));
    assign wr_h[g] = do_write & hit_h & (sec_idx == 1'(g));
    assign wr_data[g] = do_write & hit_data & (sec_idx == 1'(g));
    assign wr_attr[g] = do_write & hit_attr & (sec_idx == 1'(g));

    msi_copy #(
      .HAS_LOW(HAS_V1P1),
      .HAS_MSI(MSI_OK)
    ) u_copy (
      .sys_clk(sys_clk),
      .rst(rst),
      .wr_addr_l(wr_l[g]),
      .wr_addr_h(wr_h[g]),
      .wr_data(wr_data[g]),
      .wr_attr(wr_attr[g]),
      .wdata(req.wdata),
      .ovf_event(ovf_event[g]),
      .grant(grant[g]),
      .addr_l_word(addr_l_word[g]),
      .addr_h_word(addr_h_word[g]),
      .data_word(data_word[g]),
      .attr_word(attr_word[g]),
      .msi_write_enable(msi_write_enable[g]),
      .pend(pend[g]),
      .msi_addr(full_addr[g])
    );
  end

  // read data selection; bitmap has no write path at all
  wire [31:0] bitmap_word = BITMAP_PRESENT_FLAG ? bitmap[sec_idx] : '0;
  wire [31:0] rd_word =
    hit_bitmap ? bitmap_word :
    hit_l ? addr_l_word[sec_idx] :
    hit_h ? addr_h_word[sec_idx] :
    hit_data ? data_word[sec_idx] :
    hit_attr ? attr_word[sec_idx] :
    bw_ovf_pkg::RESET_WORD;
  wire [31:0] rsp_d = do_read ? rd_word : bw_ovf_pkg::RESET_WORD;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= bw_ovf_pkg::RESET_WORD;
    end else begin
      rsp_valid_q <= req.valid;
      rsp_rdata_q <= rsp_d;
    end
  end

  // msi issue: secure copy wins a tie; loser keeps its pending bit
  wire slot_free = ~msi_valid_q | msi_ready;
  wire pick_s = pend[bw_ovf_pkg::SEC_S];
  wire msi_load = slot_free & (|pend);
  assign grant[bw_ovf_pkg::SEC_S] = msi_load & pick_s;
  assign grant[bw_ovf_pkg::SEC_NS] = msi_load & ~pick_s;

  wire bw_ovf_pkg::msi_wr_s msi_d = '{
    addr: pick_s ? full_addr[1] : full_addr[0],
    data: pick_s ? data_word[1] : data_word[0],
    secure: pick_s
  };

  // hardwired line is suppressed while msi signalling is enabled
  wire [1:0] irq_d = ovf_event & ~msi_write_enable;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      msi_valid_q <= 1'b0;
      msi_q <= '0;
      irq_q <= 2'h0;
    end else begin
      if (msi_load) begin
        msi_q <= msi_d;
      end
      msi_valid_q <= msi_load | (msi_valid_q & ~msi_ready);
      irq_q <= irq_d;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_bitmap_read;
    do_read && hit_bitmap |=>
      rsp_valid_q && rsp_rdata_q == (BITMAP_PRESENT_FLAG ?
        ($past(sec_idx) ? $past(bitmap[1]) : $past(bitmap[0])) : 32'h0);
  endproperty
  a_bitmap_read: assert property (p_bitmap_read)
    else $error("bitmap read returned wrong word");

  property p_bitmap_absent;
    !BITMAP_PRESENT_FLAG && do_read && hit_bitmap |=> rsp_rdata_q == 32'h0;
  endproperty
  a_bitmap_absent: assert property (p_bitmap_absent)
    else $error("absent bitmap read nonzero");

  property p_bitmap_group;
    sel_s.selected_monitor_index[15:5] >= 11'(NUM_MON / 32) |->
      bitmap[bw_ovf_pkg::SEC_S] == 32'h0;
  endproperty
  a_bitmap_group: assert property (p_bitmap_group)
    else $error("bitmap set for monitors beyond the last");

  property p_bitmap_bit0;
    sel_s.resource_instance_select == 4'h0 && sel_s.selected_monitor_index[15:5] == 11'h000 |->
      bitmap[1][0] == (oflow_s[0] | oflow_long_s[0]);
  endproperty
  a_bitmap_bit0: assert property (p_bitmap_bit0)
    else $error("bitmap bit zero does not follow monitor zero");

  property p_low_zero;
    do_read && hit_l |=> rsp_rdata_q[1:0] == 2'h0;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("low address bits 1:0 not zero");

  property p_high_reserved;
    do_read && hit_h |=>
      rsp_rdata_q[31:20] == 12'h000 && (MSI_OK || rsp_rdata_q == 32'h0);
  endproperty
  a_high_reserved: assert property (p_high_reserved)
    else $error("high address reserved bits set");

  property p_low_roundtrip;
    (do_write && hit_l) ##1
      (do_read && hit_l && sec_idx == $past(sec_idx)) |=>
      rsp_rdata_q == (HAS_V1P1 ?
        ($past(req.wdata, 2) & bw_ovf_pkg::ADDR_L_MASK) : 32'h0);
  endproperty
  a_low_roundtrip: assert property (p_low_roundtrip)
    else $error("low address did not hold written value");

  property p_high_roundtrip;
    (do_write && hit_h) ##1
      (do_read && hit_h && sec_idx == $past(sec_idx)) |=>
      rsp_rdata_q == (MSI_OK ?
        ($past(req.wdata, 2) & bw_ovf_pkg::ADDR_H_MASK) : 32'h0);
  endproperty
  a_high_roundtrip: assert property (p_high_roundtrip)
    else $error("high address did not hold written value");

  property p_copy_split;
    do_write && hit_l && sec_idx |=>
      $stable(addr_l_word[bw_ovf_pkg::SEC_NS]);
  endproperty
  a_copy_split: assert property (p_copy_split)
    else $error("secure write changed nonsecure copy");

  property p_irq_suppress;
    ovf_event[1] |=> irq_q[1] == !$past(msi_write_enable[1]);
  endproperty
  a_irq_suppress: assert property (p_irq_suppress)
    else $error("hardwired interrupt wrong for enable state");

  property p_msi_needs_event;
    $rose(msi_valid_q) |->
      $past(pend[0] | pend[1]) && $past(msi_write_enable[0] | msi_write_enable[1]);
  endproperty
  a_msi_needs_event: assert property (p_msi_needs_event)
    else $error("msi write without enabled pending overflow");

  property p_msi_addr;
    msi_load |=> msi_valid_q && msi_q.addr == (msi_q.secure ?
      $past(full_addr[1]) : $past(full_addr[0])) && msi_q.addr[1:0] == 2'h0;
  endproperty
  a_msi_addr: assert property (p_msi_addr)
    else $error("msi address not formed from own copy");

  property p_msi_payload_value;
    msi_load |=> msi_q.data == (msi_q.secure ?
      $past(data_word[1]) : $past(data_word[0]));
  endproperty
  a_msi_payload_value: assert property (p_msi_payload_value)
    else $error("msi payload not the programmed value");

  property p_msi_hold;
    msi_valid_q && !msi_ready |=> msi_valid_q && $stable(msi_q);
  endproperty
  a_msi_hold: assert property (p_msi_hold)
    else $error("msi write dropped before acceptance");

  property p_msi_absent;
    !MSI_OK |-> !msi_valid_q;
  endproperty
  a_msi_absent: assert property (p_msi_absent)
    else $error("msi write issued without msi support");

  property p_write_ignored;
    do_write && hit_bitmap |=> rsp_valid_q && rsp_rdata_q == 32'h0;
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write to bitmap answered with data");

  property p_rsp_follows;
    1'b1 |=> rsp_valid_q == $past(req.valid);
  endproperty
  a_rsp_follows: assert property (p_rsp_follows)
    else $error("register answer not one cycle after request");

  property p_write_no_data;
    do_write |=> rsp_rdata_q == 32'h0;
  endproperty
  a_write_no_data: assert property (p_write_no_data)
    else $error("write answered with nonzero data");

  property p_bitmap_ris;
    int'(sel_s.resource_instance_select) >= NUM_RIS |-> bitmap[bw_ovf_pkg::SEC_S] == 32'h0;
  endproperty
  a_bitmap_ris: assert property (p_bitmap_ris)
    else $error("bitmap set for an absent resource instance");

  property p_bitmap_ns_bit;
    sel_ns.resource_instance_select == 4'h0 && sel_ns.selected_monitor_index[15:5] == 11'h001 |->
      bitmap[bw_ovf_pkg::SEC_NS][30] == (oflow_ns[62] | oflow_long_ns[62]);
  endproperty
  a_bitmap_ns_bit: assert property (p_bitmap_ns_bit)
    else $error("nonsecure bitmap bit does not follow its monitor");

  property p_pend_set;
    ovf_event[bw_ovf_pkg::SEC_NS] && msi_write_enable[bw_ovf_pkg::SEC_NS] |=>
      pend[bw_ovf_pkg::SEC_NS];
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("enabled nonsecure overflow not held pending");

  property p_irq_ns_suppress;
    ovf_event[0] |=> irq_q[0] == !$past(msi_write_enable[0]);
  endproperty
  a_irq_ns_suppress: assert property (p_irq_ns_suppress)
    else $error("nonsecure hardwired interrupt wrong for enable state");

  // a tie must not drop the losing state's request
  property p_msi_tie;
    msi_load && pend[bw_ovf_pkg::SEC_NS] && pick_s |=>
      msi_q.secure && pend[bw_ovf_pkg::SEC_NS];
  endproperty
  a_msi_tie: assert property (p_msi_tie)
    else $error("nonsecure overflow lost in a tie");

  property p_msi_drain;
    msi_valid_q && msi_ready && pend == 2'h0 |=> !msi_valid_q;
  endproperty
  a_msi_drain: assert property (p_msi_drain)
    else $error("msi write repeated after acceptance");

  c_bitmap_pending: cover property (do_read && hit_bitmap ##1
    rsp_rdata_q != 32'h0);
  c_msi_secure: cover property (msi_load && pick_s ##1 msi_ready);
  c_msi_stall: cover property (msi_valid_q && !msi_ready ##1
    msi_valid_q && msi_ready);
  c_irq_wire: cover property (irq_q[0]);
  c_msi_tie: cover property (msi_load && pend == 2'h3);

endmodule

// *** bw_ovf_pkg.sv ***
package bw_ovf_pkg;

  // register offsets inside each security frame
  localparam logic [11:0] OFF_BITMAP = 12'h898;
  localparam logic [11:0] OFF_ADDR_L = 12'h8E0;
  localparam logic [11:0] OFF_ADDR_H = 12'h8E4;
  localparam logic [11:0] OFF_DATA = 12'h8E8;
  localparam logic [11:0] OFF_ATTR = 12'h8EC;

  // bitmap group selection
  localparam logic [15:0] GROUP_MASK = 16'hFFE0;
  localparam int GROUP_BITS = 32;

  // field layouts
  localparam logic [31:0] ADDR_H_MASK = 32'h000F_FFFF;
  localparam logic [31:0] ADDR_L_MASK = 32'hFFFF_FFFC;
  localparam int ADDR_H_W = 20;
  localparam int ADDR_L_W = 30;
  localparam int ADDR_L_LSB = 2;
  localparam int MSI_ADDR_W = 52;
  localparam int ATTR_MSI_WRITE_ENABLE_POS = 0;
  localparam logic [1:0] LOW_ZERO = 2'h0;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // security state index
  localparam int SEC_NS = 0;
  localparam int SEC_S = 1;

  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [3:0] resource_instance_select;
    logic [15:0] selected_monitor_index;
  } selected_monitor_index_s;

  typedef struct packed {
    logic [51:0] addr;
    logic [31:0] data;
    logic secure;
  } msi_wr_s;

endpackage

// *** bitmap_gather.sv ***
`timescale 1ns/1ps
module bitmap_gather #(
  parameter int NUM_MON = 64,
  parameter int NUM_RIS = 1
) (
  input wire bw_ovf_pkg::selected_monitor_index_s sel,
  input wire logic [NUM_RIS*NUM_MON-1:0] oflow,
  input wire logic [NUM_RIS*NUM_MON-1:0] oflow_long,
  output logic [31:0] bitmap
);

  int base;
  int idx;
  int resource_instance_select;

  // bits past the last monitor or an absent resource instance read zero
  always_comb begin
    base = int'(sel.selected_monitor_index & bw_ovf_pkg::GROUP_MASK);
    resource_instance_select = int'(sel.resource_instance_select);
    idx = 0;
    bitmap = bw_ovf_pkg::RESET_WORD;
    for (int i = 0; i < bw_ovf_pkg::GROUP_BITS; i++) begin
      idx = base + i;
      if (idx < NUM_MON && resource_instance_select < NUM_RIS) begin
        bitmap[i] = oflow[resource_instance_select*NUM_MON+idx] |
                    oflow_long[resource_instance_select*NUM_MON+idx];
      end
    end
  end

endmodule

// *** msi_copy.sv ***
`timescale 1ns/1ps
module msi_copy #(
  parameter bit HAS_LOW = 1'b1,
  parameter bit HAS_MSI = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_addr_l,
  input wire logic wr_addr_h,
  input wire logic wr_data,
  input wire logic wr_attr,
  input wire logic [31:0] wdata,
  input wire logic ovf_event,
  input wire logic grant,
  output logic [31:0] addr_l_word,
  output logic [31:0] addr_h_word,
  output logic [31:0] data_word,
  output logic [31:0] attr_word,
  output logic msi_write_enable,
  output logic pend,
  output logic [51:0] msi_addr
);

  logic [29:0] lo_q;
  logic [19:0] hi_q;
  logic [31:0] pay_q;
  logic en_q;
  logic pend_q;
  logic pend_d;

  // a new overflow in the grant cycle keeps the request pending
  assign pend_d = (pend_q & ~grant) | (ovf_event & en_q & HAS_MSI);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lo_q <= '0;
      hi_q <= '0;
      pay_q <= '0;
      en_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      if (wr_addr_l && HAS_LOW) begin
        lo_q <= wdata[31:bw_ovf_pkg::ADDR_L_LSB];
      end
      if (wr_addr_h && HAS_MSI) begin
        hi_q <= wdata[bw_ovf_pkg::ADDR_H_W-1:0];
      end
      if (wr_data && HAS_MSI) begin
        pay_q <= wdata;
      end
      if (wr_attr && HAS_MSI) begin
        en_q <= wdata[bw_ovf_pkg::ATTR_MSI_WRITE_ENABLE_POS];
      end
      pend_q <= pend_d;
    end
  end

  assign addr_l_word = HAS_LOW ? {lo_q, bw_ovf_pkg::LOW_ZERO} : '0;
  assign addr_h_word = HAS_MSI ? {12'h000, hi_q} : '0;
  assign data_word = HAS_MSI ? pay_q : '0;
  assign attr_word = HAS_MSI ? {31'h0000_0000, en_q} : '0;
  assign msi_write_enable = en_q & HAS_MSI;
  assign pend = pend_q;
  assign msi_addr = {hi_q, lo_q, bw_ovf_pkg::LOW_ZERO};

endmodule

// *** bw_overflow_regs_test.sv ***
`timescale 1ns/1ps
module bw_overflow_regs_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  bw_ovf_pkg::reg_req_s req = '0;
  bw_ovf_pkg::selected_monitor_index_s sel_s = '0;
  bw_ovf_pkg::selected_monitor_index_s sel_ns = '0;
  logic [63:0] oflow_s = 64'h8000_0001_0000_0010;
  logic [63:0] oflow_long_s = 64'h0001_0101_0000_0001;
  logic [63:0] oflow_ns = 64'h0000_0002_0000_0000;
  logic [63:0] oflow_long_ns = 64'h4000_0000_0000_0000;
  logic [1:0] ovf_event = 2'h0;
  logic msi_ready = 1'b0;
  logic rsp_valid_q;
  logic rsp_valid_b;
  logic [31:0] rsp_rdata_q;
  logic [31:0] rsp_rdata_b;
  logic msi_valid_q;
  logic msi_valid_b;
  bw_ovf_pkg::msi_wr_s msi_q;
  logic [1:0] irq_q;
  logic [1:0] irq_b;
  wire logic [63:0] any_s = oflow_s | oflow_long_s;
  wire logic [63:0] any_ns = oflow_ns | oflow_long_ns;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  int irq_s_cnt = 0;
  int irq_ns_cnt = 0;
  int irq_b_cnt = 0;
  int msi_cyc = 0;
  int msi_b_cyc = 0;
  int n;
  int m0;

  bw_overflow_regs i_bw_overflow_regs (
    .sys_clk(sys_clk), .rst(rst), .req(req),
    .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q),
    .sel_s(sel_s), .sel_ns(sel_ns),
    .oflow_s(oflow_s), .oflow_long_s(oflow_long_s),
    .oflow_ns(oflow_ns), .oflow_long_ns(oflow_long_ns),
    .ovf_event(ovf_event), .msi_ready(msi_ready),
    .msi_valid_q(msi_valid_q), .msi_q(msi_q), .irq_q(irq_q)
  );

  // bitmap and msi absent, low address kept: shares every input
  bw_overflow_regs #(
    .BITMAP_PRESENT_FLAG(1'b0), .HAS_V1P1(1'b1), .MSI_PRESENT_FLAG(1'b0)
  ) i_bw_overflow_regs_lean (
    .sys_clk(sys_clk), .rst(rst), .req(req),
    .rsp_valid_q(rsp_valid_b), .rsp_rdata_q(rsp_rdata_b),
    .sel_s(sel_s), .sel_ns(sel_ns),
    .oflow_s(oflow_s), .oflow_long_s(oflow_long_s),
    .oflow_ns(oflow_ns), .oflow_long_ns(oflow_long_ns),
    .ovf_event(ovf_event), .msi_ready(msi_ready),
    .msi_valid_q(msi_valid_b), .msi_q(), .irq_q(irq_b)
  );

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    // outputs are unknown before the first reset edge
    if (!rst) begin
      if (irq_q[1] !== 1'b0) irq_s_cnt++;
      if (irq_q[0] !== 1'b0) irq_ns_cnt++;
      if (irq_b[1] !== 1'b0) irq_b_cnt++;
      if (msi_valid_q !== 1'b0) msi_cyc++;
      if (msi_valid_b !== 1'b0) msi_b_cyc++;
    end
    if (cycles == 2000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [63:0] seen,
      input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one access: request held for one edge, answer sampled a cycle later
  task automatic access(input logic wr, input logic sec,
      input logic [11:0] addr, input logic [31:0] wdata,
      input logic [31:0] exp);
    @(posedge sys_clk);
    req <= '{valid: 1'b1, write: wr, secure: sec, addr: addr, wdata: wdata};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    #1;
    check("rsp_valid", {63'h0, rsp_valid_q}, 64'h1);
    check("rdata", {32'h0, rsp_rdata_q}, {32'h0, exp});
    check("lean_rdata", {32'h0, rsp_rdata_b},
      {32'h0, (addr == 12'h8E0) ? exp : 32'h0});
  endtask

  // write then read of one register in consecutive cycles
  task automatic wr_rd(input logic sec, input logic [11:0] addr,
      input logic [31:0] wdata, input logic [31:0] exp);
    @(posedge sys_clk);
    req <= '{valid: 1'b1, write: 1'b1, secure: sec, addr: addr, wdata: wdata};
    @(posedge sys_clk);
    req <= '{valid: 1'b1, write: 1'b0, secure: sec, addr: addr, wdata: 32'h0};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    #1;
    check("wr_rd", {32'h0, rsp_rdata_q}, {32'h0, exp});
    check("wr_rd_lean", {32'h0, rsp_rdata_b},
      {32'h0, (addr == 12'h8E0) ? exp : 32'h0});
  endtask

  task automatic pulse(input logic [1:0] ev);
    @(posedge sys_clk);
    ovf_event <= ev;
    @(posedge sys_clk);
    ovf_event <= 2'h0;
  endtask

  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      access(1'b0, s[0], 12'h8E0, 32'h0, 32'h0);
      access(1'b0, s[0], 12'h8E4, 32'h0, 32'h0);
    end
    access(1'b1, 1'b1, 12'h8E0, 32'hFFFF_FFFF, 32'h0);
    access(1'b1, 1'b1, 12'h8E4, 32'hFFFF_FFFF, 32'h0);
    access(1'b0, 1'b1, 12'h8E0, 32'h0, 32'hFFFF_FFFC);
    access(1'b0, 1'b1, 12'h8E4, 32'h0, 32'h000F_FFFF);
    access(1'b0, 1'b0, 12'h8E0, 32'h0, 32'h0);
    access(1'b0, 1'b0, 12'h8E4, 32'h0, 32'h0);
    access(1'b1, 1'b0, 12'h8E0, 32'h1234_5677, 32'h0);
    access(1'b1, 1'b0, 12'h8E4, 32'hABCD_E123, 32'h0);
    access(1'b0, 1'b0, 12'h8E0, 32'h0, 32'h1234_5674);
    access(1'b0, 1'b0, 12'h8E4, 32'h0, 32'h000D_E123);
    access(1'b0, 1'b1, 12'h8E0, 32'h0, 32'hFFFF_FFFC);
    // back-to-back write then read sees the new value at once
    wr_rd(1'b1, 12'h8E0, 32'h0BAD_F00F, 32'h0BAD_F00C);
    wr_rd(1'b1, 12'h8E4, 32'hFFF1_2345, 32'h0001_2345);
    // scan both groups, low index bits must not shift the window
    for (int g = 0; g < 2; g++) begin
      @(posedge sys_clk);
      sel_s.selected_monitor_index <= 16'(g * 32 + 5);
      sel_ns.selected_monitor_index <= 16'(g * 32 + 31);
      access(1'b0, 1'b1, 12'h898, 32'h0, any_s[g*32 +: 32]);
      access(1'b0, 1'b0, 12'h898, 32'h0, any_ns[g*32 +: 32]);
    end
    @(posedge sys_clk);
    sel_s <= '{resource_instance_select: 4'h0, selected_monitor_index: 16'h0040};
    access(1'b0, 1'b1, 12'h898, 32'h0, 32'h0);
    @(posedge sys_clk);
    sel_s <= '{resource_instance_select: 4'h1, selected_monitor_index: 16'h0020};
    access(1'b0, 1'b1, 12'h898, 32'h0, 32'h0);
    @(posedge sys_clk);
    sel_s.resource_instance_select <= 4'h0;
    oflow_s <= 64'h0;
    access(1'b0, 1'b1, 12'h898, 32'h0, 32'h0001_0101);
    access(1'b1, 1'b1, 12'h898, 32'hFFFF_FFFF, 32'h0);
    access(1'b0, 1'b1, 12'h898, 32'h0, 32'h0001_0101);
    access(1'b0, 1'b1, 12'h8F0, 32'h0, 32'h0);
    // secure msi: stalled sink, fields held until accepted
    access(1'b1, 1'b1, 12'h8E0, 32'h8765_4323, 32'h0);
    access(1'b1, 1'b1, 12'h8E4, 32'hFFFA_5A5A, 32'h0);
    access(1'b1, 1'b1, 12'h8E8, 32'hC0DE_0001, 32'h0);
    access(1'b1, 1'b1, 12'h8EC, 32'hFFFF_FFFF, 32'h0);
    access(1'b0, 1'b1, 12'h8EC, 32'h0, 32'h1);
    pulse(2'b10);
    for (n = 0; n < 10 && msi_valid_q !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    repeat (3) @(posedge sys_clk);
    #1;
    check("msi_valid", {63'h0, msi_valid_q}, 64'h1);
    check("msi_addr", {12'h0, msi_q.addr}, 64'h000A_5A5A_8765_4320);
    check("msi_payload_value", {32'h0, msi_q.data}, 64'hC0DE_0001);
    check("msi_secure", {63'h0, msi_q.secure}, 64'h1);
    @(posedge sys_clk);
    msi_ready <= 1'b1;
    @(posedge sys_clk);
    msi_ready <= 1'b0;
    #1;
    check("msi_done", {63'h0, msi_valid_q}, 64'h0);
    check("irq_s", 64'(irq_s_cnt), 64'h0);
    check("lean_irq", 64'(irq_b_cnt), 64'h1);
    // nonsecure left disabled: hardwired pulse, no msi
    m0 = msi_cyc;
    pulse(2'b01);
    repeat (4) @(posedge sys_clk);
    check("irq_ns", 64'(irq_ns_cnt), 64'h1);
    check("msi_ns", 64'(msi_cyc - m0), 64'h0);
    check("lean_msi", 64'(msi_b_cyc), 64'h0);
    // both states enabled and firing at once: secure first, then nonsecure
    access(1'b1, 1'b0, 12'h8E8, 32'h0000_5A5A, 32'h0);
    access(1'b1, 1'b0, 12'h8EC, 32'h0000_0001, 32'h0);
    pulse(2'b11);
    @(posedge sys_clk);
    #1;
    check("msi_tie_s", {63'h0, msi_q.secure}, 64'h1);
    @(posedge sys_clk);
    msi_ready <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("msi_tie_ns", {63'h0, msi_q.secure}, 64'h0);
    check("ns_addr", {12'h0, msi_q.addr}, 64'h000D_E123_1234_5674);
    check("ns_data", {32'h0, msi_q.data}, 64'h0000_5A5A);
    @(posedge sys_clk);
    msi_ready <= 1'b0;
    #1;
    check("msi_drain", {63'h0, msi_valid_q}, 64'h0);
    check("irq_ns_quiet", 64'(irq_ns_cnt), 64'h1);
    // second reset in mid-run clears enable and addresses
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    access(1'b0, 1'b1, 12'h8EC, 32'h0, 32'h0);
    access(1'b0, 1'b1, 12'h8E0, 32'h0, 32'h0);
    summarize();
  end
endmodule
